// File: shared/eacc_regs.vh
`ifndef EACC_REGS_VH
`define EACC_REGS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define EACC_IDX_CTRL3      8'h05
`define EACC_IDX_ACC5       8'h06
`define EACC_IDX_ACC6       8'h07
`define EACC_IDX_CLEAR      8'h08
`define EACC_CTRL3_RESET    16'h0000

// ----------------------------------------------------------------
// field positions inside metering_control_three
// ----------------------------------------------------------------
`define EACC_ACC6_SRC_HI    15
`define EACC_ACC6_SRC_LO    14
`define EACC_ACC6_A_EN      13
`define EACC_ACC6_B_EN      12
`define EACC_ACC6_CMB_HI    11
`define EACC_ACC6_CMB_LO    10
`define EACC_ACC6_SGN_HI    9
`define EACC_ACC6_SGN_LO    8
`define EACC_ACC5_SRC_HI    7
`define EACC_ACC5_SRC_LO    6
`define EACC_ACC5_A_EN      5
`define EACC_ACC5_B_EN      4
`define EACC_ACC5_CMB_HI    3
`define EACC_ACC5_CMB_LO    2
`define EACC_ACC5_SGN_HI    1
`define EACC_ACC5_SGN_LO    0

// clear register bits (write one to clear)
`define EACC_CLR_ACC5_BIT   0
`define EACC_CLR_ACC6_BIT   1

// ----------------------------------------------------------------
// field encodings
// ----------------------------------------------------------------
`define EACC_SRC_POWER      2'h0
`define EACC_SRC_RMS        2'h1
`define EACC_SRC_CONST      2'h2
`define EACC_SRC_FUND       2'h3
`define EACC_PWR_ACTIVE0    2'h0
`define EACC_PWR_REACTIVE   2'h1
`define EACC_PWR_APPARENT   2'h2
`define EACC_PWR_ACTIVE3    2'h3
`define EACC_SGN_POS        2'h0
`define EACC_SGN_NEG        2'h1
`define EACC_SGN_ORIG       2'h2
`define EACC_SGN_ABS        2'h3

`endif

// File: logic/eacc_lane.v
`timescale 1ns/1ps
`default_nettype none
`include "eacc_regs.vh"

module eacc_lane #(
  parameter W = 24
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // configuration fields
  input wire [1:0] source,
  input wire en_a,
  input wire en_b,
  input wire [1:0] combine,
  input wire [1:0] sign_mode,
  // samples
  input wire sample_valid,
  input wire signed [W-1:0] p_act_a,
  input wire signed [W-1:0] p_react_a,
  input wire signed [W-1:0] p_app_a,
  input wire signed [W-1:0] irms_a,
  input wire signed [W-1:0] fund_a,
  input wire signed [W-1:0] p_act_b,
  input wire signed [W-1:0] p_react_b,
  input wire signed [W-1:0] p_app_b,
  input wire signed [W-1:0] irms_b,
  input wire signed [W-1:0] fund_b,
  input wire signed [W-1:0] const_val,
  // processed term
  output reg signed [W+1:0] term_r,
  output reg term_valid_r
);

  // ----------------------------------------------------------------
  // sign extension of a raw sample to the term width
  // ----------------------------------------------------------------
  function signed [W+1:0] eacc_sx;
    input signed [W-1:0] x;
    begin
      eacc_sx = {{2{x[W-1]}}, x};
    end
  endfunction

  // ----------------------------------------------------------------
  // power type selection for one channel
  // ----------------------------------------------------------------
  function signed [W+1:0] eacc_pick_power;
    input [1:0] sel;
    input signed [W-1:0] act;
    input signed [W-1:0] react;
    input signed [W-1:0] app;
    begin
      case (sel)
        `EACC_PWR_REACTIVE: eacc_pick_power = eacc_sx(react);
        `EACC_PWR_APPARENT: eacc_pick_power = eacc_sx(app);
        default: eacc_pick_power = eacc_sx(act);
      endcase
    end
  endfunction

  reg signed [W+1:0] a_term;
  reg signed [W+1:0] b_term;
  reg signed [W+1:0] raw;
  reg signed [W+1:0] term_nxt;

  // channel terms gated by their enables
  always @* begin
    a_term = {(W+2){1'b0}};
    b_term = {(W+2){1'b0}};
    case (source)
      `EACC_SRC_POWER: begin
        a_term = eacc_pick_power(combine, p_act_a, p_react_a, p_app_a);
        b_term = eacc_pick_power(combine, p_act_b, p_react_b, p_app_b);
      end
      `EACC_SRC_RMS: begin
        a_term = eacc_sx(irms_a);
        b_term = eacc_sx(irms_b);
      end
      `EACC_SRC_FUND: begin
        a_term = eacc_sx(fund_a);
        b_term = eacc_sx(fund_b);
      end
      default: begin
        a_term = {(W+2){1'b0}};
        b_term = {(W+2){1'b0}};
      end
    endcase
    if (!en_a)
      a_term = {(W+2){1'b0}};
    if (!en_b)
      b_term = {(W+2){1'b0}};
  end

  // combine the channels, then apply sign processing
  always @* begin
    if (source == `EACC_SRC_CONST)
      raw = eacc_sx(const_val);
    else if (source == `EACC_SRC_RMS && combine[1])
      raw = a_term - b_term;
    else
      raw = a_term + b_term;
    case (sign_mode)
      `EACC_SGN_POS: term_nxt = raw[W+1] ? {(W+2){1'b0}} : raw;
      `EACC_SGN_NEG: term_nxt = raw[W+1] ? -raw : {(W+2){1'b0}};
      `EACC_SGN_ORIG: term_nxt = raw;
      default: term_nxt = raw[W+1] ? -raw : raw;
    endcase
  end

  // register the processed term with its strobe
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_r <= {(W+2){1'b0}};
      term_valid_r <= 1'b0;
    end else begin
      term_valid_r <= sample_valid;
      if (sample_valid)
        term_r <= term_nxt;
    end
  end

endmodule // eacc_lane

`default_nettype wire

// File: logic/eacc_top.v
// Function
// - Source field per accumulator: 0 power, 1 current RMS, 2 constant, 3 fundamental.
// - Channel A contributes only while its enable bit is one.
// - Channel B contributes only while its enable bit is one.
// - For power source, combine field picks active (0,3), reactive (1), apparent (2).
// - For RMS source, combine upper bit picks sum (0) or difference (1).
// - Sign field: 0 positive only, 2 signed original, 3 absolute value.
// - Sign field 1 adds only negative values, converted to their magnitude.
`timescale 1ns/1ps
`default_nettype none
`include "eacc_regs.vh"

module eacc_top #(
  parameter W = 24,
  parameter ACC_W = 48
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // sample strobe and channel samples
  input wire sample_valid,
  input wire signed [W-1:0] p_act_a,
  input wire signed [W-1:0] p_react_a,
  input wire signed [W-1:0] p_app_a,
  input wire signed [W-1:0] irms_a,
  input wire signed [W-1:0] fund_a,
  input wire signed [W-1:0] p_act_b,
  input wire signed [W-1:0] p_react_b,
  input wire signed [W-1:0] p_app_b,
  input wire signed [W-1:0] irms_b,
  input wire signed [W-1:0] fund_b,
  input wire signed [W-1:0] const_val,
  // accumulator values
  output reg [ACC_W-1:0] acc5_value,
  output reg [ACC_W-1:0] acc6_value
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg [15:0] metering_control_three_r;
  wire signed [W+1:0] term5;
  wire signed [W+1:0] term6;
  wire term5_valid;
  wire term6_valid;
  reg [31:0] prdata_nxt;
  reg [ACC_W-1:0] acc5_nxt;
  reg [ACC_W-1:0] acc6_nxt;

  // ----------------------------------------------------------------
  // apb address decode
  // ----------------------------------------------------------------
  // true for an aligned word address in the low page at this index
  function eacc_hit;
    input [11:0] addr;
    input [7:0] index;
    begin
      eacc_hit = (addr[11:10] == 2'h0) && (addr[9:2] == index) && (addr[1:0] == 2'h0);
    end
  endfunction

  // the answer comes on the second access cycle
  wire hit_ctrl = eacc_hit(paddr, `EACC_IDX_CTRL3);
  wire hit_acc5 = eacc_hit(paddr, `EACC_IDX_ACC5);
  wire hit_acc6 = eacc_hit(paddr, `EACC_IDX_ACC6);
  wire hit_clr = eacc_hit(paddr, `EACC_IDX_CLEAR);
  wire mapped = hit_ctrl | hit_acc5 | hit_acc6 | hit_clr;
  wire access = psel & penable & ~pready;
  wire commit = psel & penable & pready & pwrite & ~pslverr;
  wire clr5 = commit & hit_clr & pwdata[`EACC_CLR_ACC5_BIT];
  wire clr6 = commit & hit_clr & pwdata[`EACC_CLR_ACC6_BIT];

  // sign extension of a processed term to accumulator width
  function [ACC_W-1:0] eacc_ext;
    input signed [W+1:0] t;
    begin
      eacc_ext = {{(ACC_W-W-2){t[W+1]}}, t};
    end
  endfunction

  // ----------------------------------------------------------------
  // datapath lanes for accumulators 5 and 6
  // ----------------------------------------------------------------
  eacc_lane #(.W(W)) u_lane5 (
    .pclk(pclk),
    .presetn(presetn),
    .source(metering_control_three_r[`EACC_ACC5_SRC_HI:`EACC_ACC5_SRC_LO]),
    .en_a(metering_control_three_r[`EACC_ACC5_A_EN]),
    .en_b(metering_control_three_r[`EACC_ACC5_B_EN]),
    .combine(metering_control_three_r[`EACC_ACC5_CMB_HI:`EACC_ACC5_CMB_LO]),
    .sign_mode(metering_control_three_r[`EACC_ACC5_SGN_HI:`EACC_ACC5_SGN_LO]),
    .sample_valid(sample_valid),
    .p_act_a(p_act_a),
    .p_react_a(p_react_a),
    .p_app_a(p_app_a),
    .irms_a(irms_a),
    .fund_a(fund_a),
    .p_act_b(p_act_b),
    .p_react_b(p_react_b),
    .p_app_b(p_app_b),
    .irms_b(irms_b),
    .fund_b(fund_b),
    .const_val(const_val),
    .term_r(term5),
    .term_valid_r(term5_valid)
  );

  eacc_lane #(.W(W)) u_lane6 (
    .pclk(pclk),
    .presetn(presetn),
    .source(metering_control_three_r[`EACC_ACC6_SRC_HI:`EACC_ACC6_SRC_LO]),
    .en_a(metering_control_three_r[`EACC_ACC6_A_EN]),
    .en_b(metering_control_three_r[`EACC_ACC6_B_EN]),
    .combine(metering_control_three_r[`EACC_ACC6_CMB_HI:`EACC_ACC6_CMB_LO]),
    .sign_mode(metering_control_three_r[`EACC_ACC6_SGN_HI:`EACC_ACC6_SGN_LO]),
    .sample_valid(sample_valid),
    .p_act_a(p_act_a),
    .p_react_a(p_react_a),
    .p_app_a(p_app_a),
    .irms_a(irms_a),
    .fund_a(fund_a),
    .p_act_b(p_act_b),
    .p_react_b(p_react_b),
    .p_app_b(p_app_b),
    .irms_b(irms_b),
    .fund_b(fund_b),
    .const_val(const_val),
    .term_r(term6),
    .term_valid_r(term6_valid)
  );

  // ----------------------------------------------------------------
  // accumulators; a term arriving with a clear starts the new sum
  // ----------------------------------------------------------------
  // next sums; the sums wrap silently at full width
  always @* begin
    acc5_nxt = acc5_value;
    acc6_nxt = acc6_value;
    if (clr5)
      acc5_nxt = term5_valid ? eacc_ext(term5) : {ACC_W{1'b0}};
    else if (term5_valid)
      acc5_nxt = acc5_value + eacc_ext(term5);
    if (clr6)
      acc6_nxt = term6_valid ? eacc_ext(term6) : {ACC_W{1'b0}};
    else if (term6_valid)
      acc6_nxt = acc6_value + eacc_ext(term6);
  end

  // accumulator registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc5_value <= {ACC_W{1'b0}};
      acc6_value <= {ACC_W{1'b0}};
    end else begin
      acc5_value <= acc5_nxt;
      acc6_value <= acc6_nxt;
    end
  end

  // ----------------------------------------------------------------
  // apb handshake: pready and pslverr pulse on the second access cycle
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      pslverr <= access & ~mapped; // unmapped or misaligned
    end
  end

  // read data mux; writes and unmapped addresses return zero
  always @* begin
    prdata_nxt = 32'h00000000;
    if (!pwrite && hit_ctrl)
      prdata_nxt = {16'h0000, metering_control_three_r};
    else if (!pwrite && hit_acc5)
      prdata_nxt = acc5_value[31:0];
    else if (!pwrite && hit_acc6)
      prdata_nxt = acc6_value[31:0];
  end

  // read data register, loaded once per access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (access)
      prdata <= prdata_nxt;
  end

  // ----------------------------------------------------------------
  // control register; only the lower half is stored
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      metering_control_three_r <= `EACC_CTRL3_RESET;
    else if (commit && hit_ctrl)
      metering_control_three_r <= pwdata[15:0];
  end

endmodule // eacc_top

`default_nettype wire

// File: tb/eacc_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module eacc_top_props #(parameter W = 24, parameter ACC_W = 48) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // samples and sums
  input wire logic sample_valid,
  input wire logic signed [W-1:0] const_val,
  input wire logic [ACC_W-1:0] acc5_value,
  input wire logic [ACC_W-1:0] acc6_value
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // helpers
  // ----
  wire logic hit = paddr inside {12'h014, 12'h018, 12'h01C, 12'h020};
  wire logic wr = psel && penable && pready && pwrite;
  wire logic clr = wr && paddr == 12'h020;
  wire logic [ACC_W-1:0] cext = {{(ACC_W-W){const_val[W-1]}}, const_val};
  logic [15:0] ctl_r;
  // shadow of the committed control word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_r <= 16'h0000;
    else if (wr && paddr == 12'h014) ctl_r <= pwdata[15:0];
  end
  sequence s_quiet;
    (!sample_valid && !clr) ##1 !clr;
  endsequence
  sequence s_const5;
    (sample_valid && ctl_r[7:6] == 2'h2 && ctl_r[1:0] == 2'h2 && !clr) ##1 !clr;
  endsequence
  chk_ready_timing: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready late");
  chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready not a pulse");
  chk_err_unmapped: assert property (pready && !hit |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped not refused");
  chk_err_mapped: assert property (pready && hit |-> !pslverr)
    else $error("mapped refused");
  chk_ctrl_upper: assert property (pready && !pwrite && paddr == 12'h014 |-> prdata == {16'h0000, ctl_r})
    else $error("control readback wrong");
  chk_clear_read: assert property (pready && !pwrite && paddr == 12'h020 |-> prdata == 32'h0)
    else $error("clear reads nonzero");
  chk_acc_read: assert property (pready && !pwrite && paddr == 12'h018 && $stable(acc5_value)
    |-> prdata == acc5_value[31:0]) else $error("acc5 read wrong");
  chk_acc_hold: assert property (s_quiet |=> $stable(acc5_value) && $stable(acc6_value))
    else $error("accumulator moved without sample");
  chk_const_add: assert property (s_const5 |=> acc5_value == $past(acc5_value) + $past(cext, 2))
    else $error("constant not added");
endmodule // eacc_top_props
bind eacc_top eacc_top_props #(.W(W), .ACC_W(ACC_W)) u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_valid, .const_val, .acc5_value, .acc6_value);
`default_nettype wire

// File: tb/eacc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, v) begin check_count++; if ((v) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %0h got %0h", n, e, v); end end
module eacc_top_tb;
  localparam int W = 24;
  localparam int ACC_W = 48;
  localparam logic [11:0] IDX_CTL = 12'h005; // index, byte address is four times it
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sample_valid = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  logic [ACC_W-1:0] acc5_value, acc6_value;
  // act, react, app, rms, fund for a then b, then the constant
  logic signed [W-1:0] s [0:10] = '{24'h000005, 24'hFFFFF9, 24'h00000B, 24'h000014, 24'hFFFFFD,
    24'h000002, 24'h000004, 24'hFFFFFA, 24'h00001E, 24'h000009, 24'hFFFFF3};
  int n_fail = 0, check_count = 0;
  always #4 pclk = ~pclk;
  eacc_top #(.W(W), .ACC_W(ACC_W)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .p_act_a(s[0]), .p_react_a(s[1]), .p_app_a(s[2]), .irms_a(s[3]),
    .fund_a(s[4]), .p_act_b(s[5]), .p_react_b(s[6]), .p_app_b(s[7]), .irms_b(s[8]), .fund_b(s[9]),
    .const_val(s[10]), .acc5_value(acc5_value), .acc6_value(acc6_value));
  // expected term of one sample for one accumulator's eight control bits
  function automatic logic [ACC_W-1:0] term(input logic [7:0] f);
    logic signed [ACC_W-1:0] a, b, t;
    case (f[7:6])
      2'h0: begin
        a = f[3:2] == 2'h1 ? s[1] : f[3:2] == 2'h2 ? s[2] : s[0];
        b = f[3:2] == 2'h1 ? s[6] : f[3:2] == 2'h2 ? s[7] : s[5];
      end
      2'h1: begin
        a = s[3];
        b = f[3] ? -s[8] : s[8];
      end
      default: begin
        a = s[4];
        b = s[9];
      end
    endcase
    t = (f[5] ? a : '0) + (f[4] ? b : '0);
    if (f[7:6] == 2'h2) t = s[10];
    case (f[1:0])
      2'h0: t = t[ACC_W-1] ? '0 : t;
      2'h1: t = t[ACC_W-1] ? -t : '0;
      2'h3: t = t[ACC_W-1] ? -t : t;
      default: ;
    endcase
    return t;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one apb transfer, answer taken at the edge where pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16 && pready !== 1'b1; i++) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      n_fail++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // one sample strobe, sums visible two cycles on
  task automatic sample();
    sample_valid <= 1'b1;
    @(posedge pclk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  initial begin
    logic [7:0] k6;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("acc5 reset", 48'h0, acc5_value)
    apb(1'b0, IDX_CTL * 4, 32'h0);
    `CHK("ctrl reset", 32'h0, rd)
    apb(1'b0, 12'h024, 32'h0);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, 12'h015, 32'hFFFF);
    `CHK("misaligned", 1'b1, err)
    apb(1'b0, IDX_CTL * 4, 32'h0);
    `CHK("misaligned ignored", 32'h0, rd)
    // every setting of accumulator 5, accumulator 6 on the same pattern XORed with A5
    for (int k = 0; k < 256; k++) begin
      k6 = 8'(k) ^ 8'hA5;
      apb(1'b1, 12'h020, 32'h3);
      apb(1'b1, IDX_CTL * 4, {16'hFFFF, k6, 8'(k)});
      apb(1'b0, IDX_CTL * 4, 32'h0);
      `CHK("ctrl readback", {16'h0, k6, 8'(k)}, rd)
      sample();
      `CHK("acc5", term(8'(k)), acc5_value)
      `CHK("acc6", term(k6), acc6_value)
    end
    sample();
    `CHK("acc5 twice", term(8'hFF) << 1, acc5_value)
    apb(1'b1, 12'h018, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    `CHK("acc5 read only", 32'(term(8'hFF) << 1), rd)
    finish_test();
  end
endmodule // eacc_top_tb
`default_nettype wire
